// ---- verilog/tcr_cfg.svh ----
// Bit positions, reset values and timing counts of the tape command register upper half
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH
`define TCR_BIT_ERROR       15
`define TCR_BIT_DENS_HIGH   14
`define TCR_BIT_DENS_LOW    13
`define TCR_BIT_PWR_CLEAR   12
`define TCR_BIT_READY       7
`define TCR_BIT_INT_ENABLE  6
`define TCR_BIT_GO          0
`define TCR_DENS_RESET      2'h0
`define TCR_DENS_CORE_DUMP  2'h3
`define TCR_INIT_CYCLES     4'h1
`endif

// ---- verilog/tcr_pkg.sv ----
// Types shared by the tape command register modules
package tcr_pkg;
    typedef enum logic [1:0] {TCR_IDLE, TCR_BUSY} tcr_state_t;
    typedef struct packed {
        logic       coreDump;
        logic       sevenTrack;
        logic [1:0] density;
    } tcr_mode_t;
endpackage : tcr_pkg

// ---- verilog/tcr_mode_if.sv ----
// Packing mode carried from the register bank to the channel gating module
`timescale 1ns/1ps
interface tcr_mode_if;
    import tcr_pkg::*;
    tcr_mode_t mode;
    modport src (output mode);
    modport dst (input mode);
endinterface : tcr_mode_if

// ---- verilog/tcr_write_gate.sv ----
// Maps data buffer bits onto tape write lines with channel gating and core dump nibble split
`timescale 1ns/1ps
module tcr_write_gate
    import tcr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    tcr_mode_if.dst         modeIf,
    input  wire logic [7:0] dataByte,
    input  wire logic       secondChar,
    output logic      [7:0] writeLines_r
);
    logic [7:0] nibbleSrc;
    logic [7:0] writeLines_nxt;
    always_comb
    begin
        nibbleSrc = dataByte;
        if (modeIf.mode.coreDump)
        begin
            // Low nibble first, high nibble second [RQ17]
            nibbleSrc = secondChar ? {4'h0, dataByte[7:4]} : {4'h0, dataByte[3:0]};
        end
    end
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++)
        begin : g_chan
            // Channel ch is fed from bit 7-ch of nibbleSrc, which is the buffer itself outside core dump [RQ15]
            always_comb
            begin
                if ((ch < 2 && modeIf.mode.sevenTrack) || (ch >= 2 && ch < 4 && modeIf.mode.coreDump))
                    writeLines_nxt[ch] = 1'b0; // [RQ16]
                else
                    writeLines_nxt[ch] = nibbleSrc[7 - ch];
            end
        end
    endgenerate
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            writeLines_r <= 8'h00;
        else
            writeLines_r <= writeLines_nxt;
    end
    a_chan_gate_seven : assert property (@(posedge sys_clk) disable iff (rst)
        $past(modeIf.mode.sevenTrack) |-> writeLines_r[1:0] == 2'h0) // [RQ16]
        else $error("seven track channels not gated");
    a_dump_first_char : assert property (@(posedge sys_clk) disable iff (rst)
        $past(modeIf.mode.coreDump) && !$past(secondChar) |->
        writeLines_r[7:4] == {$past(dataByte[0]), $past(dataByte[1]), $past(dataByte[2]), $past(dataByte[3])}) // [RQ17]
        else $error("core dump first char wrong");
endmodule : tcr_write_gate

// ---- verilog/tcr_init_pulse.sv ----
// Builds the internal initialize as the OR of power clear write and bus initialize, high for as long as either is high
`timescale 1ns/1ps
`include "tcr_cfg.svh"
module tcr_init_pulse
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic busInit,
    input  wire logic powerClearWrite,
    output logic      initPulse
);
    // Power clear is a write strobe, so no stored bit can hold init on [RQ22]
    always_comb initPulse = busInit | powerClearWrite; // [RQ1] [RQ2]
    a_init_follows : assert property (@(posedge sys_clk) disable iff (rst)
        powerClearWrite |-> initPulse) // [RQ1]
        else $error("power clear did not initialize");
endmodule : tcr_init_pulse

// ---- verilog/tape_command_register_upper.sv ----
// Upper half of the tape command register with initialize, error summary and density logic
// Behaviour
// RQ1: Writing one into power clear bit 12 starts controller initialize.
// RQ2: Bus initialize line also initializes the controller.
// RQ3: Bit 15 reads as OR of all latched status errors.
// RQ4: Grant late, missing memory, illegal command, bad tape set error immediately.
// RQ5: Length, cyclic, parity, end-of-file errors reach summary only after check char.
// RQ6: Tape end sets error only forward, not rewinding, after check char.
// RQ7: Error sets transfer done; done with unit ready sets controller ready.
// RQ8: Error raises interrupt request only while interrupt enable is set.
// RQ9: Bad unit selection counts as illegal command error.
// RQ10: Initialize or next go clears all errors and summary flag.
// RQ11: Density code 00/01/10 is 200/556/800 seven track, 11 nine track.
// RQ12: Density bits captured on high byte write, each driven to transport.
// RQ13: Core dump when both density bits set and seven track tape.
// RQ14: Core dump forces low density line to zero, giving 800 bpi.
// RQ15: Buffer bits 0 to 3 map onto tape channels 7 to 4.
// RQ16: Channels 1,0 off on seven track; 3,2 also off in core dump.
// RQ17: Core dump byte written as low nibble then high nibble on lines 7-4.
// RQ18: Power clear clears controller and transports, nothing else on bus.
// RQ19: Internal initialize drives a dedicated transport clear line.
// RQ20: Controller ready set on completion, initialize or error; cleared by go.
// RQ21: Interrupt occurs when ready becomes set while enable is one.
// RQ22: Power clear acts as write pulse, not a stored bit.
`timescale 1ns/1ps
`include "tcr_cfg.svh"
module tape_command_register_upper
    import tcr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        busInit,
    input  wire logic        high_byte_write_strobe,
    input  wire logic        low_byte_write_strobe,
    input  wire logic [15:0] busDataIn,
    input  wire logic        grant_late_error,
    input  wire logic        missing_memory_error,
    input  wire logic        illegal_command_error,
    input  wire logic        unitSelectFault,
    input  wire logic        bad_tape_error,
    input  wire logic        record_length_error,
    input  wire logic        cyclic_check_error,
    input  wire logic        lateral_parity_error,
    input  wire logic        endOfFileError,
    input  wire logic        tape_end_marker,
    input  wire logic        check_char_detected,
    input  wire logic        reverse_spacing,
    input  wire logic        rewinding,
    input  wire logic        seven_track_tape,
    input  wire logic        tape_unit_ready,
    input  wire logic        operationDone,
    input  wire logic [7:0]  dataBuffer,
    input  wire logic        secondChar,
    input  wire logic        interruptAck,
    output logic [15:0]      readData_r,
    output logic             density_high_bit_r,
    output logic             density_low_bit_r,
    output logic             transport_clear_line_r,
    output logic             controller_ready_flag_r,
    output logic             transferDone_r,
    output logic             interrupt_request_flag_r,
    output logic             coreDump_r,
    output logic [7:0]       write_line_seven_down_r
);
    // ------------------------------------------------------------
    // Initialize
    // ------------------------------------------------------------
    logic initPulse;
    logic powerClearWrite;
    logic goWrite;
    assign powerClearWrite = high_byte_write_strobe & busDataIn[`TCR_BIT_PWR_CLEAR];
    assign goWrite         = low_byte_write_strobe & busDataIn[`TCR_BIT_GO];

    tcr_init_pulse u_init
    (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .busInit         (busInit),
        .powerClearWrite (powerClearWrite),
        .initPulse       (initPulse)
    );

    // Only controller and transports see this; no bus-wide reset is driven [RQ18]
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            transport_clear_line_r <= 1'b0;
        else
            transport_clear_line_r <= initPulse; // [RQ19]
    end

    // ------------------------------------------------------------
    // Error latches and summary
    // ------------------------------------------------------------
    logic [3:0] fastErr_r;
    logic [3:0] slowErr_r;
    logic       endErr_r;
    logic [3:0] fastErrIn;
    logic [3:0] slowErrIn;
    logic       errorFlag_r;
    logic       summarySet;
    logic       errClear;
    assign errClear  = initPulse | goWrite;
    // Unit selection faults fold into the illegal command latch [RQ9]
    assign fastErrIn = {grant_late_error, missing_memory_error,
                        illegal_command_error | unitSelectFault, bad_tape_error};
    assign slowErrIn = {record_length_error, cyclic_check_error, lateral_parity_error, endOfFileError};

    // Set wins over clear so a fault in the go cycle is kept
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fastErr_r <= 4'h0;
        else
            fastErr_r <= (errClear ? 4'h0 : fastErr_r) | fastErrIn; // [RQ10]
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            slowErr_r <= 4'h0;
        else
            slowErr_r <= (errClear ? 4'h0 : slowErr_r) | slowErrIn; // [RQ5] [RQ10]
    end

    logic endQual;
    assign endQual = tape_end_marker & ~reverse_spacing & ~rewinding & check_char_detected; // [RQ6]
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            endErr_r <= 1'b0;
        else
            endErr_r <= (errClear ? 1'b0 : endErr_r) | endQual;
    end

    // Slow errors wait for the check character so the record can finish
    // Latched fast faults already set the flag in their own cycle; feeding them back would block the go clear
    assign summarySet = (|fastErrIn)                                                 // [RQ4]
                      | (check_char_detected & ((|slowErrIn) | (|slowErr_r)))        // [RQ5]
                      | endQual;                                                    // [RQ6]

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            errorFlag_r <= 1'b0;
        else if (summarySet)
            errorFlag_r <= 1'b1; // [RQ3]
        else if (errClear)
            errorFlag_r <= 1'b0; // [RQ10]
    end

    // ------------------------------------------------------------
    // Done, ready and interrupt
    // ------------------------------------------------------------
    logic intEnable_r;
    always_ff @(posedge sys_clk)
    begin
        if (rst || initPulse)
            intEnable_r <= 1'b0;
        else if (low_byte_write_strobe)
            intEnable_r <= busDataIn[`TCR_BIT_INT_ENABLE];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            transferDone_r <= 1'b0;
        else if (summarySet || operationDone)
            transferDone_r <= 1'b1; // [RQ7]
        else if (errClear)
            transferDone_r <= 1'b0;
    end

    logic readySet;
    // Done is cleared by the same go, so it must not set ready again in that cycle
    assign readySet = initPulse | (transferDone_r & tape_unit_ready & ~goWrite); // [RQ7] [RQ20]
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            controller_ready_flag_r <= 1'b1;
        else if (readySet)
            controller_ready_flag_r <= 1'b1;
        else if (goWrite)
            controller_ready_flag_r <= 1'b0; // [RQ20]
    end

    logic readyRise;
    assign readyRise = readySet & ~controller_ready_flag_r;
    always_ff @(posedge sys_clk)
    begin
        if (rst || initPulse)
            interrupt_request_flag_r <= 1'b0;
        else if (intEnable_r && (readyRise || summarySet))
            interrupt_request_flag_r <= 1'b1; // [RQ8] [RQ21]
        else if (interruptAck)
            interrupt_request_flag_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Density and core dump
    // ------------------------------------------------------------
    logic [1:0] density_r;
    logic       coreDumpNow;
    always_ff @(posedge sys_clk)
    begin
        if (rst || initPulse)
            density_r <= `TCR_DENS_RESET;
        else if (high_byte_write_strobe)
            density_r <= {busDataIn[`TCR_BIT_DENS_HIGH], busDataIn[`TCR_BIT_DENS_LOW]}; // [RQ12]
    end

    assign coreDumpNow = (density_r == `TCR_DENS_CORE_DUMP) & seven_track_tape; // [RQ13]

    // Transport decodes the code; 11 on seven track becomes 10 here [RQ11]
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            density_high_bit_r <= 1'b0;
            density_low_bit_r  <= 1'b0;
            coreDump_r         <= 1'b0;
        end
        else
        begin
            density_high_bit_r <= density_r[1];               // [RQ12]
            density_low_bit_r  <= density_r[0] & ~coreDumpNow; // [RQ14]
            coreDump_r         <= coreDumpNow;
        end
    end

    tcr_mode_if modeBus ();
    assign modeBus.mode = '{coreDump: coreDumpNow, sevenTrack: seven_track_tape, density: density_r};

    tcr_write_gate u_gate
    (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .modeIf       (modeBus),
        .dataByte     (dataBuffer),
        .secondChar   (secondChar),
        .writeLines_r (write_line_seven_down_r)
    );

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    logic [15:0] readData_nxt;
    always_comb
    begin
        readData_nxt = 16'h0000;
        readData_nxt[`TCR_BIT_ERROR]      = errorFlag_r; // [RQ3]
        readData_nxt[`TCR_BIT_DENS_HIGH]  = density_r[1];
        readData_nxt[`TCR_BIT_DENS_LOW]   = density_r[0];
        readData_nxt[`TCR_BIT_READY]      = controller_ready_flag_r;
        readData_nxt[`TCR_BIT_INT_ENABLE] = intEnable_r;
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            readData_r <= 16'h0000;
        else
            readData_r <= readData_nxt;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fast_fault;
        (|fastErrIn);
    endsequence
    a_fast_error_set : assert property (@(posedge sys_clk) disable iff (rst)
        s_fast_fault |=> errorFlag_r ##1 readData_r[15]) // [RQ4]
        else $error("fast error not summarized");
    a_slow_error_wait : assert property (@(posedge sys_clk) disable iff (rst)
        (|slowErrIn) && !check_char_detected && !errorFlag_r && !(|fastErrIn) && !(|fastErr_r)
        && !(|slowErr_r) && !endQual |=> !errorFlag_r) // [RQ5]
        else $error("slow error summarized early");
    a_end_reverse_off : assert property (@(posedge sys_clk) disable iff (rst)
        tape_end_marker && reverse_spacing |-> !endQual) // [RQ6]
        else $error("tape end counted while reversing");
    a_go_clears_err : assert property (@(posedge sys_clk) disable iff (rst)
        goWrite && !summarySet |=> !errorFlag_r && fastErr_r == 4'h0) // [RQ10]
        else $error("go did not clear errors");
    a_error_sets_done : assert property (@(posedge sys_clk) disable iff (rst)
        summarySet |=> transferDone_r) // [RQ7]
        else $error("error did not set done");
    a_irq_needs_enable : assert property (@(posedge sys_clk) disable iff (rst)
        $rose(interrupt_request_flag_r) |-> $past(intEnable_r)) // [RQ8]
        else $error("interrupt without enable");
    a_core_dump_low : assert property (@(posedge sys_clk) disable iff (rst)
        coreDumpNow |=> density_high_bit_r && !density_low_bit_r) // [RQ14]
        else $error("core dump density not 10");
    a_clear_line_init : assert property (@(posedge sys_clk) disable iff (rst)
        busInit |=> transport_clear_line_r ##1 controller_ready_flag_r) // [RQ19]
        else $error("init not forwarded");
    a_go_clears_ready : assert property (@(posedge sys_clk) disable iff (rst)
        goWrite && !readySet |=> !controller_ready_flag_r) // [RQ20]
        else $error("go left ready set");
    a_summary_readback : assert property (@(posedge sys_clk) disable iff (rst)
        errorFlag_r |=> readData_r[`TCR_BIT_ERROR]) // [RQ3]
        else $error("error flag not readable");
    a_slow_after_check : assert property (@(posedge sys_clk) disable iff (rst)
        check_char_detected && (|slowErr_r) |=> errorFlag_r) // [RQ5]
        else $error("slow error not summarized after check char");
    a_unit_fault_illegal : assert property (@(posedge sys_clk) disable iff (rst)
        unitSelectFault |=> fastErr_r[1] && errorFlag_r) // [RQ9]
        else $error("unit select fault not latched");
    a_init_clears_err : assert property (@(posedge sys_clk) disable iff (rst)
        initPulse && !summarySet && !(|slowErrIn) |=> !errorFlag_r && fastErr_r == 4'h0 && slowErr_r == 4'h0) // [RQ10]
        else $error("init left errors set");
    a_density_capture : assert property (@(posedge sys_clk) disable iff (rst)
        high_byte_write_strobe && !initPulse |=> density_r == $past(busDataIn[`TCR_BIT_DENS_HIGH:`TCR_BIT_DENS_LOW])) // [RQ12]
        else $error("density not captured");
    a_core_dump_flag : assert property (@(posedge sys_clk) disable iff (rst)
        (density_r == `TCR_DENS_CORE_DUMP) && seven_track_tape |=> coreDump_r) // [RQ13]
        else $error("core dump not flagged");
    a_ready_on_done : assert property (@(posedge sys_clk) disable iff (rst)
        transferDone_r && tape_unit_ready && !goWrite |=> controller_ready_flag_r) // [RQ7]
        else $error("done with unit ready left ready clear");
    a_done_on_op : assert property (@(posedge sys_clk) disable iff (rst)
        operationDone |=> transferDone_r) // [RQ20]
        else $error("completion did not set done");
    a_irq_on_ready : assert property (@(posedge sys_clk) disable iff (rst)
        intEnable_r && readyRise && !initPulse |=> interrupt_request_flag_r) // [RQ21]
        else $error("ready rise gave no interrupt");

    // Init and power clear: the clear line follows every init cycle one cycle later and drops one cycle after init ends
    a_init_sets_ready : assert property (@(posedge sys_clk) disable iff (rst)
        initPulse |=> controller_ready_flag_r) // [RQ20]
        else $error("init did not set ready");
    a_init_clears_irq : assert property (@(posedge sys_clk) disable iff (rst)
        initPulse |=> !interrupt_request_flag_r && !intEnable_r) // [RQ18]
        else $error("init left interrupt state");
    a_power_clear_init : assert property (@(posedge sys_clk) disable iff (rst)
        powerClearWrite |=> transport_clear_line_r) // [RQ1] [RQ19]
        else $error("power clear not forwarded");
    sequence s_power_clear_once;
        powerClearWrite && !busInit ##1 !initPulse;
    endsequence
    a_power_clear_pulse : assert property (@(posedge sys_clk) disable iff (rst)
        s_power_clear_once |=> !transport_clear_line_r) // [RQ22]
        else $error("power clear held init on");
endmodule : tape_command_register_upper

// ---- verification/tcr_transport_model.sv ----
// Behavioural master tape transport facing the command register block
`timescale 1ns/1ps
module tcr_transport_model
(
    input  wire logic sys_clk,
    input  wire logic sevenSel,
    input  wire logic densHigh,
    input  wire logic densLow,
    input  wire logic clearLine,
    output logic      seven_track_tape,
    output logic      tape_unit_ready,
    output int        bpi,
    output int        clrCnt
);
    // Tape type is whatever the bench mounts
    assign seven_track_tape = sevenSel;
    always_comb
    begin
        case ({densHigh, densLow})
            2'h0:    bpi = 200;
            2'h1:    bpi = 556;
            default: bpi = 800;
        endcase
    end
    initial clrCnt = 0;
    initial tape_unit_ready = 1'b1;
    // Every attached transport drops ready for a cycle while it is cleared
    always @(posedge sys_clk)
    begin
        tape_unit_ready <= !clearLine;
        if (clearLine)
            clrCnt <= clrCnt + 1;
    end
endmodule : tcr_transport_model

// ---- verification/tb.sv ----
// Self-checking testbench of the tape command register upper half
`timescale 1ns/1ps
module tb;
    logic        sys_clk, rst, busInit, hiWr, loWr, irqAck, opDone, secondChar, sevenSel;
    logic        tapeEnd, chkChar, revSpace, rewind;
    logic [4:0]  fastErr;
    logic [3:0]  slowErr;
    logic [15:0] busData, readData;
    logic [7:0]  dataBuf, wLines;
    logic        densHi, densLo, clrLine, ready, xferDone, irq, coreDump, seven, unitRdy;
    int          bpi, clrCnt, error_cnt, checked;

    tape_command_register_upper DUT (.sys_clk(sys_clk), .rst(rst), .busInit(busInit),
        .high_byte_write_strobe(hiWr), .low_byte_write_strobe(loWr), .busDataIn(busData),
        .grant_late_error(fastErr[4]), .missing_memory_error(fastErr[3]),
        .illegal_command_error(fastErr[2]), .unitSelectFault(fastErr[1]), .bad_tape_error(fastErr[0]),
        .record_length_error(slowErr[3]), .cyclic_check_error(slowErr[2]),
        .lateral_parity_error(slowErr[1]), .endOfFileError(slowErr[0]), .tape_end_marker(tapeEnd),
        .check_char_detected(chkChar), .reverse_spacing(revSpace), .rewinding(rewind),
        .seven_track_tape(seven), .tape_unit_ready(unitRdy), .operationDone(opDone), .dataBuffer(dataBuf),
        .secondChar(secondChar), .interruptAck(irqAck), .readData_r(readData),
        .density_high_bit_r(densHi), .density_low_bit_r(densLo), .transport_clear_line_r(clrLine),
        .controller_ready_flag_r(ready), .transferDone_r(xferDone), .interrupt_request_flag_r(irq),
        .coreDump_r(coreDump), .write_line_seven_down_r(wLines));

    tcr_transport_model u_xport (.sys_clk(sys_clk), .sevenSel(sevenSel), .densHigh(densHi),
        .densLow(densLo), .clearLine(clrLine), .seven_track_tape(seven), .tape_unit_ready(unitRdy),
        .bpi(bpi), .clrCnt(clrCnt));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : clk

    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task end_sim;
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task wr(input logic hi, input logic [15:0] d);
        @(posedge sys_clk);
        hiWr <= hi;
        loWr <= !hi;
        busData <= d;
        @(posedge sys_clk);
        hiWr <= 1'b0;
        loWr <= 1'b0;
    endtask : wr

    task pulse(input int which);
        @(posedge sys_clk);
        if (which < 5) fastErr <= 5'h01 << which;
        else if (which == 5) irqAck <= 1'b1;
        else opDone <= 1'b1;
        @(posedge sys_clk);
        fastErr <= 5'h00;
        irqAck <= 1'b0;
        opDone <= 1'b0;
        clk(2);
        #1;
    endtask : pulse

    // Core dump keeps one nibble on lines 7..4; channel order runs against buffer order
    function automatic logic [7:0] expLines(logic [7:0] b, logic sv, logic cd, logic sc);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[7-i] = b[i];
        if (cd) r = sc ? {b[4], b[5], b[6], b[7], 4'h0} : {b[0], b[1], b[2], b[3], 4'h0};
        else if (sv) r[1:0] = 2'h0;
        return r;
    endfunction : expLines

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_density;
        logic cd;
        logic [7:0] d;
        for (int c = 0; c < 8; c++)
        begin
            cd = (c[1:0] == 2'h3) && c[2];
            @(posedge sys_clk);
            sevenSel <= c[2];
            wr(1'b1, {1'b0, c[1:0], 13'h0000});
            clk(3);
            #1;
            chk(16'(readData[14:13]), 16'(c[1:0]), "density readback");
            chk(16'({densHi, densLo}), 16'({c[1], c[0] & !cd}), "density lines");
            chk(16'(coreDump), 16'(cd), "core dump");
            chk(16'(bpi), (c[1:0] == 2'h0) ? 16'h00C8 : (c[1:0] == 2'h1) ? 16'h022C : 16'h0320, "bpi");
            for (int k = 0; k < 4; k++)
            begin
                d = k[0] ? 8'hA5 : 8'h3C;
                @(posedge sys_clk);
                dataBuf <= d;
                secondChar <= k[1];
                clk(3);
                #1;
                chk(16'(wLines), 16'(expLines(d, c[2], cd, k[1])), "write lines");
            end
        end
        @(posedge sys_clk);
        sevenSel <= 1'b0;
    endtask : t_density

    task t_fast;
        for (int i = 0; i < 5; i++)
        begin
            pulse(i);
            clk(1);
            #1;
            chk(16'(readData[15]), 16'h0001, "fast error");
            chk(16'({xferDone, ready}), 16'h0003, "done and ready");
            wr(1'b0, 16'h0001);
            clk(3);
            #1;
            chk(16'({readData[15], ready}), 16'h0000, "go clear");
            pulse(6);
            chk(16'(ready), 16'h0001, "done sets ready");
        end
    endtask : t_fast

    task t_slow;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            slowErr <= 4'h1 << i;
            @(posedge sys_clk);
            slowErr <= 4'h0;
            clk(3);
            #1;
            chk(16'(readData[15]), 16'h0000, "slow error early");
            @(posedge sys_clk);
            chkChar <= 1'b1;
            clk(3);
            #1;
            chk(16'(readData[15]), 16'h0001, "slow error after check");
            @(posedge sys_clk);
            chkChar <= 1'b0;
            wr(1'b0, 16'h0001);
        end
    endtask : t_slow

    task t_tape_end;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge sys_clk);
            {revSpace, rewind} <= k[1:0];
            tapeEnd <= 1'b1;
            chkChar <= 1'b1;
            clk(3);
            #1;
            chk(16'(readData[15]), 16'(k == 0), "tape end");
            @(posedge sys_clk);
            {tapeEnd, chkChar, revSpace, rewind} <= 4'h0;
            wr(1'b0, 16'h0001);
        end
    endtask : t_tape_end

    task t_irq;
        pulse(2);
        chk(16'(irq), 16'h0000, "irq masked");
        wr(1'b0, 16'h0040);
        pulse(5);
        pulse(3);
        chk(16'({irq, readData[6]}), 16'h0003, "irq on error");
        wr(1'b0, 16'h0041);
        pulse(5);
        chk(16'({irq, ready}), 16'h0000, "go idle");
        pulse(6);
        chk(16'({irq, ready, xferDone}), 16'h0007, "irq on ready");
    endtask : t_irq

    task t_init;
        int c0;
        c0 = clrCnt;
        @(posedge sys_clk);
        busInit <= 1'b1;
        @(posedge sys_clk);
        busInit <= 1'b0;
        clk(3);
        #1;
        chk(16'(clrCnt - c0), 16'h0001, "bus init clear");
        pulse(0);
        c0 = clrCnt;
        wr(1'b1, 16'h1000);
        clk(4);
        #1;
        chk(readData, 16'h0080, "power clear");
        chk(16'(clrCnt > c0), 16'h0001, "transport cleared");
        chk(16'(clrLine), 16'h0000, "clear not held");
    endtask : t_init

    initial
    begin
        {rst, busInit, hiWr, loWr, irqAck, opDone, secondChar, sevenSel} = 8'hFF & 8'h80;
        {tapeEnd, chkChar, revSpace, rewind} = 4'h0;
        fastErr = 5'h00;
        slowErr = 4'h0;
        busData = 16'h0000;
        dataBuf = 8'h00;
        error_cnt = 0;
        checked = 0;
        clk(4);
        rst <= 1'b0;
        clk(2);
        #1;
        chk(readData, 16'h0080, "reset readback");
        chk(16'({xferDone, irq, clrLine, ready}), 16'h0001, "reset flags");
        t_density();
        t_fast();
        t_slow();
        t_tape_end();
        t_irq();
        t_init();
        end_sim();
    end

    initial
    begin
        clk(20000);
        error_cnt++;
        end_sim();
    end
endmodule : tb
